// ===== hdl/exec_pkg.sv
// Constants for the subtract, decrement and watchdog-kick execute logic.
// Assumes an 8-bit core with 14-bit program words and a 7-bit file address.
package exec_pkg;
    localparam int DATA_W      = 8;
    localparam int ADDR_W      = 7;
    localparam int WORD_W      = 14;
    localparam int PRESCALE_W  = 8;

    localparam logic [13:0] KICK_WORD      = 14'h0064;
    localparam logic [5:0]  DEC_FILE_CODE  = 6'h03;
    localparam logic [5:0]  FILE_SUB_CODE  = 6'h02;
    localparam logic [4:0]  LIT_SUB_CODE   = 5'h1e;
    localparam int          OP6_POS        = 8;
    localparam int          OP5_POS        = 9;
    localparam int          DEST_POS       = 7;

    localparam logic [7:0]  ACC_RESET      = 8'h00;
    localparam logic [7:0]  WDOG_RESET     = 8'h00;
    localparam logic        EXPIRY_RESET   = 1'b1;
    localparam logic        SLEEP_RESET    = 1'b1;
    localparam logic        FLAG_RESET     = 1'b0;
    localparam logic [7:0]  DEC_STEP       = 8'h01;
endpackage

// ===== hdl/sub_if.sv
// Operand and result bundle between the execute top and its subtractor.
// Assumes purely combinational use inside one clock domain.
`timescale 1ns/1ps
interface sub_if;
    logic [7:0] minuend;
    logic [7:0] subtrahend;
    logic [7:0] difference;
    logic       noBorrow;
    logic       nibbleNoBorrow;
    logic       isZero;

    modport unit (input minuend, input subtrahend,
                  output difference, output noBorrow, output nibbleNoBorrow, output isZero);
    modport user (output minuend, output subtrahend,
                  input difference, input noBorrow, input nibbleNoBorrow, input isZero);
endinterface

// ===== hdl/sub_unit.sv
// Eight-bit subtractor with inverted-borrow flags.
// Assumes operands are stable within the cycle.
`timescale 1ns/1ps
module sub_unit (
    sub_if.unit port
);
    logic [8:0] full;
    logic [4:0] nibble;

    always_comb begin
        full   = {1'b0, port.minuend} - {1'b0, port.subtrahend};
        nibble = {1'b0, port.minuend[3:0]} - {1'b0, port.subtrahend[3:0]};
        port.difference     = full[7:0];
        port.noBorrow       = ~full[8];
        port.nibbleNoBorrow = ~nibble[4];
        port.isZero         = (full[7:0] == 8'h00);
    end
endmodule

// ===== hdl/exec_unit.sv
// Execute logic for watchdog kick, decrement file and the two subtracts.
// Assumes fileRdData holds the register addressed by instr[6:0] in the same cycle.
`timescale 1ns/1ps
module exec_unit (
    input  wire logic                          core_clk,
    input  wire logic                          nrst,
    input  wire logic                          instrValid,
    input  wire logic [exec_pkg::WORD_W-1:0]   instr,
    input  wire logic [exec_pkg::DATA_W-1:0]   fileRdData,
    input  wire logic                          watchdogRun,
    output logic      [exec_pkg::DATA_W-1:0]   acc,
    output logic                               fileWrEn,
    output logic      [exec_pkg::ADDR_W-1:0]   fileWrAddr,
    output logic      [exec_pkg::DATA_W-1:0]   fileWrData,
    output logic                               carryFlag,
    output logic                               nibbleNoBorrowFlag,
    output logic                               zeroFlag,
    output logic                               expiryFlag,
    output logic                               sleepFlag,
    output logic      [exec_pkg::DATA_W-1:0]   watchdogCounter,
    output logic      [exec_pkg::PRESCALE_W-1:0] prescaler
);
    logic [1:0] rstSync;
    logic       rstN;

    // Reset is released through two stages so the whole block leaves reset on one edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstN = rstSync[1];

    sub_if subBus ();
    sub_unit uSub (
        .port (subBus)
    );

    logic isKick;
    logic isDecFile;
    logic isLitSub;
    logic isFileSub;
    logic dest;

    always_comb begin
        isKick    = instrValid && (instr == exec_pkg::KICK_WORD);
        isDecFile = instrValid && (instr[13:exec_pkg::OP6_POS] == exec_pkg::DEC_FILE_CODE);
        isLitSub  = instrValid && (instr[13:exec_pkg::OP5_POS] == exec_pkg::LIT_SUB_CODE);
        isFileSub = instrValid && (instr[13:exec_pkg::OP6_POS] == exec_pkg::FILE_SUB_CODE);
        dest      = instr[exec_pkg::DEST_POS];
    end

    always_comb begin
        if (isDecFile) begin
            subBus.minuend    = fileRdData;
            subBus.subtrahend = exec_pkg::DEC_STEP;
        end else if (isLitSub) begin
            subBus.minuend    = instr[7:0];
            subBus.subtrahend = acc;
        end else begin
            subBus.minuend    = fileRdData;
            subBus.subtrahend = acc;
        end
    end

    logic [7:0] next_acc;
    logic       next_fileWrEn;
    logic [6:0] next_fileWrAddr;
    logic [7:0] next_fileWrData;
    logic       next_carryFlag;
    logic       next_nibbleNoBorrowFlag;
    logic       next_zeroFlag;
    logic       next_expiryFlag;
    logic       next_sleepFlag;

    always_comb begin
        next_acc                = acc;
        next_fileWrEn           = 1'b0;
        next_fileWrAddr         = fileWrAddr;
        next_fileWrData         = fileWrData;
        next_carryFlag          = carryFlag;
        next_nibbleNoBorrowFlag = nibbleNoBorrowFlag;
        next_zeroFlag           = zeroFlag;
        next_expiryFlag         = expiryFlag;
        next_sleepFlag          = sleepFlag;
        if (isKick) begin
            next_expiryFlag = 1'b1;
            next_sleepFlag  = 1'b1;
        end else if (isDecFile || isFileSub) begin
            if (dest) begin
                next_fileWrEn   = 1'b1;
                next_fileWrAddr = instr[6:0];
                next_fileWrData = subBus.difference;
            end else begin
                next_acc = subBus.difference;
            end
            next_zeroFlag = subBus.isZero;
            if (isFileSub) begin
                next_carryFlag          = subBus.noBorrow;
                next_nibbleNoBorrowFlag = subBus.nibbleNoBorrow;
            end
        end else if (isLitSub) begin
            next_acc                = subBus.difference;
            next_zeroFlag           = subBus.isZero;
            next_carryFlag          = subBus.noBorrow;
            next_nibbleNoBorrowFlag = subBus.nibbleNoBorrow;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            acc                <= exec_pkg::ACC_RESET;
            fileWrEn           <= 1'b0;
            fileWrAddr         <= 7'h00;
            fileWrData         <= 8'h00;
            carryFlag          <= exec_pkg::FLAG_RESET;
            nibbleNoBorrowFlag <= exec_pkg::FLAG_RESET;
            zeroFlag           <= exec_pkg::FLAG_RESET;
            expiryFlag         <= exec_pkg::EXPIRY_RESET;
            sleepFlag          <= exec_pkg::SLEEP_RESET;
        end else begin
            acc                <= next_acc;
            fileWrEn           <= next_fileWrEn;
            fileWrAddr         <= next_fileWrAddr;
            fileWrData         <= next_fileWrData;
            carryFlag          <= next_carryFlag;
            nibbleNoBorrowFlag <= next_nibbleNoBorrowFlag;
            zeroFlag           <= next_zeroFlag;
            expiryFlag         <= next_expiryFlag;
            sleepFlag          <= next_sleepFlag;
        end
    end

    logic [7:0] next_watchdogCounter;
    logic [7:0] next_prescaler;

    // Kick beats a tick in the same cycle so a late kick never lets the count advance
    always_comb begin
        next_watchdogCounter = watchdogCounter;
        next_prescaler       = prescaler;
        if (isKick) begin
            next_watchdogCounter = exec_pkg::WDOG_RESET;
            next_prescaler       = 8'h00;
        end else if (watchdogRun) begin
            next_prescaler = prescaler + 8'h01;
            if (prescaler == 8'hff) begin
                next_watchdogCounter = watchdogCounter + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            watchdogCounter <= exec_pkg::WDOG_RESET;
            prescaler       <= 8'h00;
        end else begin
            watchdogCounter <= next_watchdogCounter;
            prescaler       <= next_prescaler;
        end
    end

    kick_clear_a: assert property (@(posedge core_clk) disable iff (!rstN)
        isKick |=> (watchdogCounter == 8'h00) && (prescaler == 8'h00))
        else $error("Kick did not clear watchdog");

    kick_flags_a: assert property (@(posedge core_clk) disable iff (!rstN)
        isKick |=> expiryFlag && sleepFlag && (carryFlag == $past(carryFlag))
                   && (nibbleNoBorrowFlag == $past(nibbleNoBorrowFlag))
                   && (zeroFlag == $past(zeroFlag)) && (acc == $past(acc)))
        else $error("Kick flag update wrong");

    dec_acc_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (isDecFile && !dest) |=> (acc == $past(fileRdData) - 8'h01) && !fileWrEn
                   && (zeroFlag == ($past(fileRdData) == 8'h01)))
        else $error("Decrement to accumulator wrong");

    dec_file_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (isDecFile && dest) |=> fileWrEn && (fileWrData == $past(fileRdData) - 8'h01)
                   && (fileWrAddr == $past(instr[6:0])) && (carryFlag == $past(carryFlag))
                   && (zeroFlag == ($past(fileRdData) == 8'h01))
                   && (nibbleNoBorrowFlag == $past(nibbleNoBorrowFlag)) && (acc == $past(acc)))
        else $error("Decrement to file wrong");

    lit_sub_a: assert property (@(posedge core_clk) disable iff (!rstN)
        isLitSub |=> (acc == $past(instr[7:0]) - $past(acc)) && !fileWrEn)
        else $error("Literal subtract wrong");

    file_sub_a: assert property (@(posedge core_clk) disable iff (!rstN)
        isFileSub |=> ($past(dest) ? (fileWrEn && fileWrData == $past(fileRdData) - $past(acc))
                                   : (!fileWrEn && acc == $past(fileRdData) - $past(acc))))
        else $error("File subtract wrong");

    carry_borrow_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (isLitSub || isFileSub) |=> carryFlag == ($past(subBus.minuend) >= $past(subBus.subtrahend)))
        else $error("Carry not inverted borrow");

    nibble_borrow_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (isLitSub || isFileSub) |=>
            nibbleNoBorrowFlag == ($past(subBus.minuend[3:0]) >= $past(subBus.subtrahend[3:0])))
        else $error("Nibble flag wrong");

    one_cycle_a: assert property (@(posedge core_clk) disable iff (!rstN)
        !(isDecFile || isFileSub || isLitSub) |=> !fileWrEn)
        else $error("Stray file write");
endmodule

// ===== tb/subtract_decrement_wdt_clear_exec_tb_top.sv
// Self-checking bench for the subtract, decrement and watchdog-kick execute logic.
// Assumes the bench plays core and file memory, driving all inputs on falling edges.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmpCount++; if ((got) !== (ex)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module subtract_decrement_wdt_clear_exec_tb_top;
    logic        core_clk    = 1'b0;
    logic        nrst        = 1'b0;
    logic        instrValid  = 1'b0;
    logic [13:0] instr       = 14'h0000;
    logic [7:0]  fileRdData  = 8'h00;
    logic        watchdogRun = 1'b0;
    logic [7:0]  acc, fileWrData, watchdogCounter, prescaler;
    logic [6:0]  fileWrAddr;
    logic        fileWrEn, carryFlag, nibbleNoBorrowFlag, zeroFlag, expiryFlag, sleepFlag;
    logic [7:0]  expAcc      = 8'h00;
    logic        expC        = 1'b0;
    logic        expNibble   = 1'b0;
    logic        expZ        = 1'b0;
    int          miscompares = 0;
    int          cmpCount    = 0;

    exec_unit DUT (.core_clk(core_clk), .nrst(nrst), .instrValid(instrValid), .instr(instr),
        .fileRdData(fileRdData), .watchdogRun(watchdogRun), .acc(acc), .fileWrEn(fileWrEn),
        .fileWrAddr(fileWrAddr), .fileWrData(fileWrData), .carryFlag(carryFlag),
        .nibbleNoBorrowFlag(nibbleNoBorrowFlag), .zeroFlag(zeroFlag), .expiryFlag(expiryFlag),
        .sleepFlag(sleepFlag), .watchdogCounter(watchdogCounter), .prescaler(prescaler));

    always #25 core_clk = ~core_clk;

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Valid stays high so back-to-back words never toggle it within one step
    task automatic run(input logic [13:0] w, input logic [7:0] fr);
        instrValid = 1'b1;
        instr = w;
        fileRdData = fr;
        @(negedge core_clk);
    endtask

    task automatic idle();
        instrValid = 1'b0;
        @(negedge core_clk);
    endtask

    task automatic checkCore();
        `CHK("acc", expAcc, acc)
        `CHK("carry", expC, carryFlag)
        `CHK("nibble", expNibble, nibbleNoBorrowFlag)
        `CHK("zero", expZ, zeroFlag)
    endtask

    task automatic doSub(input bit lit, input bit dest, input logic [7:0] k, input logic [7:0] fr,
                         input logic [6:0] addr);
        logic [7:0] m;
        logic [7:0] d;
        m = lit ? k : fr;
        d = m - expAcc;
        expC = m >= expAcc;
        expNibble = m[3:0] >= expAcc[3:0];
        expZ = d == 8'h00;
        run(lit ? {exec_pkg::LIT_SUB_CODE, addr[0], k} : {exec_pkg::FILE_SUB_CODE, dest, addr}, fr);
        if (lit || !dest) expAcc = d;
        `CHK("subWrEn", !lit && dest, fileWrEn)
        if (!lit && dest) begin
            `CHK("subWrData", d, fileWrData)
            `CHK("subWrAddr", addr, fileWrAddr)
        end
        checkCore();
    endtask

    task automatic doDec(input bit dest, input logic [7:0] fr, input logic [6:0] addr);
        logic [7:0] d;
        d = fr - exec_pkg::DEC_STEP;
        expZ = d == 8'h00;
        run({exec_pkg::DEC_FILE_CODE, dest, addr}, fr);
        if (!dest) expAcc = d;
        `CHK("decWrEn", dest, fileWrEn)
        if (dest) begin
            `CHK("decWrData", d, fileWrData)
            `CHK("decWrAddr", addr, fileWrAddr)
        end
        checkCore();
    endtask

    task automatic t_reset();
        `CHK("rstWrEn", 1'b0, fileWrEn)
        `CHK("rstExpiry", 1'b1, expiryFlag)
        `CHK("rstSleep", 1'b1, sleepFlag)
        `CHK("rstCounter", 8'h00, watchdogCounter)
        checkCore();
        $display("reset test done");
    endtask

    task automatic t_literal();
        logic [7:0] lits [6] = '{8'h02, 8'h05, 8'h05, 8'h10, 8'h00, 8'hf2};
        for (int i = 0; i < 6; i++) begin
            doSub(1'b1, 1'b0, lits[i], 8'h5a, 7'(i));
        end
        $display("literal test done");
    endtask

    task automatic t_filesub();
        doSub(1'b1, 1'b0, expAcc + 8'h02, 8'h00, 7'h00);
        doSub(1'b0, 1'b1, 8'h00, 8'h03, 7'h05);
        doSub(1'b0, 1'b1, 8'h00, 8'h02, 7'h7f);
        doSub(1'b0, 1'b1, 8'h00, 8'h01, 7'h00);
        idle();
        `CHK("wrEnPulse", 1'b0, fileWrEn)
        doSub(1'b0, 1'b0, 8'h00, 8'h20, 7'h11);
        $display("file subtract test done");
    endtask

    task automatic t_decrement();
        doDec(1'b1, 8'h01, 7'h7f);
        doDec(1'b1, 8'h00, 7'h03);
        doDec(1'b0, 8'h80, 7'h10);
        $display("decrement test done");
    endtask

    task automatic t_kick();
        watchdogRun = 1'b1;
        repeat (300) @(negedge core_clk);
        run(exec_pkg::KICK_WORD, 8'h00);
        `CHK("kickCounter", 8'h00, watchdogCounter)
        `CHK("kickPrescale", 8'h00, prescaler)
        `CHK("kickExpiry", 1'b1, expiryFlag)
        `CHK("kickSleep", 1'b1, sleepFlag)
        `CHK("kickWrEn", 1'b0, fileWrEn)
        checkCore();
        idle();
        `CHK("tickAfterKick", 8'h01, prescaler)
        watchdogRun = 1'b0;
        $display("kick test done");
    endtask

    task automatic t_unknown();
        run(14'h0000, 8'h33);
        run(14'h3a05, 8'h33);
        `CHK("unkWrEn", 1'b0, fileWrEn)
        checkCore();
        instrValid = 1'b0;
        instr = {exec_pkg::DEC_FILE_CODE, 1'b1, 7'h01};
        @(negedge core_clk);
        `CHK("noValidWrEn", 1'b0, fileWrEn)
        checkCore();
        $display("refusal test done");
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        stop_test();
    end

    initial begin
        repeat (5) @(negedge core_clk);
        nrst = 1'b1;
        repeat (3) @(negedge core_clk);
        t_reset();
        t_literal();
        t_filesub();
        t_decrement();
        t_kick();
        t_unknown();
        stop_test();
    end
endmodule
